/* hdl/sscs_top.sv */
// Purpose: Spindle sine commutation sequencer with APB register port.
// Assumes: All inputs synchronous to clk; APB slave with no wait states.
// Notes:   Phase U (index 0) is the winding opened for zero-crossing sense.
//
// What this block does
// - Spin clock is system clock halved by default, undivided when prescale set.
// - Each electrical period splits into 48 samples with per-phase duty values.
// - Profile chops two phases while the third holds its low side fully on.
// - Zero-crossing period timer runs at spin clock/3, scaled to spin clock/48 units.
// - Down counter loads measured period, strobes at zero, then reloads.
// - Address counter advances on each sample strobe and selects duty values.
// - PWM period is 512 spin clocks, independent of sample rate.
// - Duty values carry 9 bits of resolution.
// - PWM counter resets at each detected zero crossing in closed-loop modes.
// - Chopping duty is profile entry times drive amplitude.
// - Six-bit supply reading trims the PWM period to hold drive voltage.
// - Supply ADC clock is system_clock_in/8 or system_clock_in/4; result applied per PWM cycle.
// - Phase U is tri-stated once per cycle for a programmable window in the closed-loop six-step and sine modes.
// - Six-step profile holds six configurations of eight entries each.
// - Load command copies the offset value into the address counter.
// - Sense state drives until current trips, mirrors it, stores rise time.
// - Sense state cuts PWM on current trip; firmware then coasts.
// - Rotor position is derived from the stored rise times.
// - Rising edge of the step bit advances the address counter by one.
// - Prescale bit picks spin clock and ADC divider together.
// - Feed-forward enable bit switches supply compensation on or off.
// - Drive amplitude is an eight-bit register field.
`timescale 1ns/1ps
`default_nettype none
module sscs_top #(
  parameter int TC_W   = 16,
  parameter int RISE_W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        zero_crossing,
  input  wire logic        ilim_trip,
  input  wire logic [5:0]  supply_adc_data,
  output var  logic        supply_adc_clk,
  output var  logic        zc_pin_out,
  output var  logic        sample_strobe,
  output var  logic [2:0]  hs_on,
  output var  logic [2:0]  ls_on
);

  // Register fields.
  logic                spin_clock_prescale_sel_q;
  logic                feedforward_comp_enable_q;
  logic                step_bit_q;
  logic                load_bit_q;
  sscs_pkg::sscs_mode_t mode_q;
  logic [7:0]          drive_amplitude_q;
  logic [4:0]          torque_optimizer_offset_q;
  logic [4:0]          win_width_q;
  logic                step_pulse_q;
  logic                load_sample_position_q;

  // Sequencing state.
  logic                div2_q;
  logic                spin_en;
  logic [2:0]          adc_div_q;
  logic                adc_en;
  logic [5:0]          adc_q;
  logic                adc_fast_q;
  logic [1:0]          pre3_q;
  logic [TC_W+3:0]     per_cnt_q;
  logic [TC_W-1:0]     zc_period_q;
  logic [TC_W-1:0]     scan_cnt_q;
  logic [5:0]          addr_q;
  logic                zc_q;
  logic                zc_rise;
  logic [9:0]          pwm_cnt_q;
  logic [9:0]          pwm_top_q;
  logic                pwm_wrap;
  logic                ilim_seen_q;
  logic                ilim_cut_q;
  logic [RISE_W-1:0]   rise_cnt_q;
  logic [RISE_W-1:0]   rise_mem [0:5];
  logic [2:0]          rotor_pos_q;
  logic                cl_mode;
  logic                wr_acc;
  logic [5:0]          win_dist;
  sscs_pkg::sscs_drive_t drv_d;

  // Rising half of the profile hump, 16 entries, full scale 511.
  function automatic logic [8:0] hump(input logic [3:0] i);
    case (i)
      4'h0: hump = 9'h032;
      4'h1: hump = 9'h064;
      4'h2: hump = 9'h095;
      4'h3: hump = 9'h0c4;
      4'h4: hump = 9'h0f1;
      4'h5: hump = 9'h11b;
      4'h6: hump = 9'h141;
      4'h7: hump = 9'h163;
      4'h8: hump = 9'h181;
      4'h9: hump = 9'h19a;
      4'ha: hump = 9'h1ae;
      4'hb: hump = 9'h1be;
      4'hc: hump = 9'h1c8;
      4'hd: hump = 9'h1ce;
      4'he: hump = 9'h1f0;
      default: hump = 9'h1ff;
    endcase
  endfunction

  // Position of phase p within the cycle, phases 16 samples apart.
  function automatic logic [5:0] ph_pos(input logic [5:0] a,
                                         input int p);
    logic [6:0] s;
    s = 7'(a) + 7'(p * 16);
    if (s >= 7'(sscs_pkg::N_SAMPLES)) begin
      s = s - 7'(sscs_pkg::N_SAMPLES);
    end
    if (s >= 7'(sscs_pkg::N_SAMPLES)) begin
      s = s - 7'(sscs_pkg::N_SAMPLES);
    end
    ph_pos = s[5:0];
  endfunction

  assign spin_en = spin_clock_prescale_sel_q | div2_q;
  assign adc_en  = (adc_div_q == 3'h0);
  assign zc_rise = zero_crossing & ~zc_q;
  assign pwm_wrap = spin_en & (pwm_cnt_q >= pwm_top_q);
  assign cl_mode = (mode_q == sscs_pkg::SSCS_CL_SIX) ||
                   (mode_q == sscs_pkg::SSCS_CL_SIN) ||
                   (mode_q == sscs_pkg::SSCS_CL_COAST);
  assign wr_acc  = psel & penable & pready & pwrite;
  assign win_dist = ({1'b0, torque_optimizer_offset_q} >= addr_q) ?
                    ({1'b0, torque_optimizer_offset_q} - addr_q) :
                    ({1'b0, torque_optimizer_offset_q} + sscs_pkg::N_SAMPLES
                     - addr_q);

  // No wait state: pready rises in the first access cycle and answers once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel & ~penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (paddr == sscs_pkg::ADDR_CTRL) begin
        prdata[sscs_pkg::CTRL_PRESC] <= spin_clock_prescale_sel_q;
        prdata[sscs_pkg::CTRL_FFW]   <= feedforward_comp_enable_q;
        prdata[sscs_pkg::CTRL_STEP]  <= step_bit_q;
        prdata[sscs_pkg::CTRL_LOAD]  <= load_bit_q;
        prdata[sscs_pkg::CTRL_MODE +: 3] <= mode_q;
      end else if (paddr == sscs_pkg::ADDR_AMP) begin
        prdata[7:0] <= drive_amplitude_q;
      end else if (paddr == sscs_pkg::ADDR_OFFS) begin
        prdata[4:0] <= torque_optimizer_offset_q;
        prdata[sscs_pkg::OFFS_WIN +: 5] <= win_width_q;
      end else if (paddr == sscs_pkg::ADDR_STAT) begin
        prdata[5:0]   <= addr_q;
        prdata[10:8]  <= rotor_pos_q;
        prdata[16]    <= ilim_seen_q;
        prdata[29:24] <= adc_q;
      end else if (paddr == sscs_pkg::ADDR_PER) begin
        prdata[TC_W-1:0] <= zc_period_q;
      end else if (paddr == sscs_pkg::ADDR_RISE) begin
        prdata[RISE_W-1:0] <= rise_mem[addr_q[5:3]];
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writable fields; step and load act on a 0 to 1 transition.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spin_clock_prescale_sel_q <= 1'b0;
      feedforward_comp_enable_q <= 1'b0;
      step_bit_q                <= 1'b0;
      load_bit_q                <= 1'b0;
      mode_q                    <= sscs_pkg::SSCS_OL_COAST;
      drive_amplitude_q         <= 8'h00;
      torque_optimizer_offset_q <= 5'h00;
      win_width_q               <= 5'h00;
      step_pulse_q              <= 1'b0;
      load_sample_position_q    <= 1'b0;
    end else begin
      step_pulse_q           <= 1'b0;
      load_sample_position_q <= 1'b0;
      if (wr_acc && paddr == sscs_pkg::ADDR_CTRL) begin
        spin_clock_prescale_sel_q <= pwdata[sscs_pkg::CTRL_PRESC];
        feedforward_comp_enable_q <= pwdata[sscs_pkg::CTRL_FFW];
        step_bit_q   <= pwdata[sscs_pkg::CTRL_STEP];
        load_bit_q   <= pwdata[sscs_pkg::CTRL_LOAD];
        step_pulse_q <= pwdata[sscs_pkg::CTRL_STEP] & ~step_bit_q;
        load_sample_position_q <= pwdata[sscs_pkg::CTRL_LOAD] & ~load_bit_q;
        mode_q <= sscs_pkg::sscs_mode_t'(pwdata[sscs_pkg::CTRL_MODE +: 3]);
      end
      if (wr_acc && paddr == sscs_pkg::ADDR_AMP) begin
        drive_amplitude_q <= pwdata[7:0];
      end
      if (wr_acc && paddr == sscs_pkg::ADDR_OFFS) begin
        torque_optimizer_offset_q <= pwdata[4:0];
        win_width_q <= pwdata[sscs_pkg::OFFS_WIN +: 5];
      end
    end
  end

  // Clock enables for the spin clock and the supply ADC.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div2_q         <= 1'b0;
      adc_div_q      <= 3'h0;
      supply_adc_clk <= 1'b0;
      adc_q          <= 6'h20;
      adc_fast_q     <= 1'b0;
    end else begin
      div2_q <= ~div2_q;
      if (adc_en) begin
        adc_div_q <= spin_clock_prescale_sel_q ?
                     sscs_pkg::ADC_DIV_FS : sscs_pkg::ADC_DIV_SL;
        adc_fast_q <= spin_clock_prescale_sel_q;
        adc_q <= supply_adc_data;
      end else begin
        adc_div_q <= adc_div_q - 3'h1;
      end
      // Divider and threshold switch together at reload, so a prescale
      // write never stretches or clips a converter clock pulse.
      supply_adc_clk <= (adc_div_q > (adc_fast_q ? 3'h1 : 3'h3));
    end
  end

  // Zero-crossing period timer and the sample strobe down counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zc_q          <= 1'b0;
      pre3_q        <= 2'h0;
      per_cnt_q     <= '0;
      zc_period_q   <= '0;
      scan_cnt_q    <= '0;
      sample_strobe <= 1'b0;
    end else begin
      zc_q          <= zero_crossing;
      sample_strobe <= 1'b0;
      if (zc_rise && cl_mode) begin
        // Units of 3 clocks divided by 16 give the period in 48ths.
        zc_period_q <= per_cnt_q[TC_W+3:sscs_pkg::TC_SHIFT];
        per_cnt_q   <= '0;
        pre3_q      <= 2'h0;
        scan_cnt_q  <= per_cnt_q[TC_W+3:sscs_pkg::TC_SHIFT] - 1'b1;
      end else if (spin_en) begin
        if (pre3_q == sscs_pkg::TIMER_PRE) begin
          pre3_q <= 2'h0;
          if (~&per_cnt_q) begin
            per_cnt_q <= per_cnt_q + 1'b1;
          end
        end else begin
          pre3_q <= pre3_q + 2'h1;
        end
        if (scan_cnt_q == '0) begin
          // Reloading one below the period makes each sample Tc spin clocks.
          scan_cnt_q    <= zc_period_q - 1'b1;
          sample_strobe <= cl_mode;
        end else begin
          scan_cnt_q <= scan_cnt_q - 1'b1;
        end
      end
    end
  end

  // Memory address counter: load beats zero crossing beats step or strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 6'h00;
    end else if (load_sample_position_q) begin
      addr_q <= {1'b0, torque_optimizer_offset_q};
    end else if (zc_rise && cl_mode) begin
      addr_q <= {1'b0, torque_optimizer_offset_q};
    end else if (step_pulse_q || sample_strobe) begin
      addr_q <= (addr_q == sscs_pkg::N_SAMPLES - 6'h1) ?
                6'h00 : addr_q + 6'h1;
    end
  end

  // PWM counter; supply reading sets the period once per cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= 10'h000;
      pwm_top_q <= sscs_pkg::PWM_TOP;
    end else if (zc_rise && cl_mode) begin
      pwm_cnt_q <= 10'h000;
    end else if (pwm_wrap) begin
      pwm_cnt_q <= 10'h000;
      // Higher supply stretches the period so mean voltage stays put;
      // the cost is a PWM rate that moves with the supply.
      pwm_top_q <= feedforward_comp_enable_q ?
                   sscs_pkg::PWM_BASE + {4'h0, adc_q} :
                   sscs_pkg::PWM_TOP;
    end else if (spin_en) begin
      pwm_cnt_q <= pwm_cnt_q + 10'h001;
    end
  end

  // Inductive sense: rise time capture and current cut per PWM cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ilim_seen_q <= 1'b0;
      ilim_cut_q  <= 1'b0;
      rise_cnt_q  <= '0;
      for (int i = 0; i < 6; i++) begin
        rise_mem[i] <= '0;
      end
    end else if (mode_q != sscs_pkg::SSCS_IND_SENS) begin
      ilim_seen_q <= 1'b0;
      ilim_cut_q  <= 1'b0;
      rise_cnt_q  <= '0;
    end else begin
      if (ilim_trip) begin
        ilim_cut_q <= 1'b1;
      end else if (pwm_wrap) begin
        ilim_cut_q <= 1'b0;
      end
      if (ilim_trip && !ilim_seen_q) begin
        ilim_seen_q <= 1'b1;
        rise_mem[addr_q[5:3]] <= rise_cnt_q;
      end else if (!ilim_seen_q && spin_en && ~&rise_cnt_q) begin
        rise_cnt_q <= rise_cnt_q + 1'b1;
      end
    end
  end

  // Shortest rise time marks the configuration aligned with the rotor.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rotor_pos_q <= 3'h0;
    end else begin
      logic [2:0]        best;
      logic [RISE_W-1:0] bv;
      best = 3'h0;
      bv   = rise_mem[0];
      for (int i = 1; i < 6; i++) begin
        if (rise_mem[i] < bv) begin
          bv   = rise_mem[i];
          best = 3'(i);
        end
      end
      rotor_pos_q <= best;
    end
  end

  // Per-phase drive from the profile.
  always_comb begin
    logic [5:0]  s;
    logic [8:0]  full;
    logic [16:0] prod;
    logic        six;
    s    = 6'h00;
    full = 9'h000;
    prod = 17'h00000;
    six  = (mode_q == sscs_pkg::SSCS_OPEN_LOOP_SIX_STEP) ||
           (mode_q == sscs_pkg::SSCS_CL_SIX) ||
           (mode_q == sscs_pkg::SSCS_IND_SENS);
    drv_d = '0;
    for (int p = 0; p < 3; p++) begin
      s = ph_pos(addr_q, p);
      if (s < sscs_pkg::SECT_LEN) begin
        drv_d.ls[p] = 1'b1;
      end else if (six) begin
        // Configurations change on multiples of eight entries.
        // Float 8, high 16, float 8 after the low run of 16.
        if (s >= 6'h18 && s < 6'h28) begin
          drv_d.hs[p] = ~ilim_cut_q;
          drv_d.ls[p] = ilim_cut_q;
        end
      end else begin
        full = (s < 6'h20) ? hump(4'(s - 6'h10)) : hump(4'(6'h2f - s));
        prod = full * drive_amplitude_q;
        drv_d.hs[p] = ({1'b0, prod[16:8]} > pwm_cnt_q);
        drv_d.ls[p] = ~drv_d.hs[p];
      end
    end
    if ((mode_q == sscs_pkg::SSCS_CL_SIX ||
         mode_q == sscs_pkg::SSCS_CL_SIN) &&
        win_dist != 6'h00 && {win_dist, 1'b0} <= {2'h0, win_width_q} + 7'h1)
    begin
      drv_d.hs[0] = 1'b0;
      drv_d.ls[0] = 1'b0;
    end
    if (mode_q == sscs_pkg::SSCS_OL_COAST ||
        mode_q == sscs_pkg::SSCS_CL_COAST) begin
      drv_d = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_on      <= 3'h0;
      ls_on      <= 3'h0;
      zc_pin_out <= 1'b0;
    end else begin
      hs_on <= drv_d.hs;
      ls_on <= drv_d.ls;
      zc_pin_out <= (mode_q == sscs_pkg::SSCS_IND_SENS) ?
                    ilim_trip : zero_crossing;
    end
  end

endmodule
`default_nettype wire

/* hdl/sscs_pkg.sv */
// Purpose: Constants and types for the spindle sine commutation sequencer.
// Assumes: APB register map with 32-bit aligned words.
// Notes:   Register offsets and the control and window field positions of the block live here.
package sscs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AMP  = 8'h04;
  localparam logic [7:0] ADDR_OFFS = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_PER  = 8'h10;
  localparam logic [7:0] ADDR_RISE = 8'h14;
  localparam int CTRL_PRESC = 0;
  localparam int CTRL_FFW   = 1;
  localparam int CTRL_STEP  = 2;
  localparam int CTRL_LOAD  = 3;
  localparam int CTRL_MODE  = 4;
  localparam int OFFS_WIN   = 8;
  localparam logic [5:0] N_SAMPLES  = 6'h30;
  localparam logic [5:0] SECT_LEN   = 6'h10;
  localparam logic [9:0] PWM_TOP    = 10'h1ff;
  localparam logic [9:0] PWM_BASE   = 10'h1e0;
  localparam logic [2:0] ADC_DIV_SL = 3'h7;
  localparam logic [2:0] ADC_DIV_FS = 3'h3;
  localparam logic [1:0] TIMER_PRE  = 2'h2;
  localparam int TC_SHIFT = 4;
  localparam int DUTY_W   = 9;
  typedef enum logic [2:0] {
    SSCS_OL_COAST = 3'b000,
    SSCS_CL_COAST = 3'b001,
    SSCS_IND_SENS = 3'b010,
    SSCS_OPEN_LOOP_SIX_STEP   = 3'b011,
    SSCS_OPEN_LOOP_SINE   = 3'b100,
    SSCS_CL_SIX   = 3'b101,
    SSCS_CL_SIN   = 3'b110
  } sscs_mode_t;
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } sscs_drive_t;
endpackage

/* verif/sscs_checker.sv */
// Purpose: Port assertions for the spindle sequencer.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to the top from the bench file.
`timescale 1ns/1ps
`default_nettype none
module sscs_checker #(
  parameter int TC_W   = 16,
  parameter int RISE_W = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        zero_crossing,
  input wire logic        ilim_trip,
  input wire logic [5:0]  supply_adc_data,
  input wire logic        supply_adc_clk,
  input wire logic        zc_pin_out,
  input wire logic        sample_strobe,
  input wire logic [2:0]  hs_on,
  input wire logic [2:0]  ls_on
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence adc_high_s;
    supply_adc_clk [*2];
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("setup cycle not answered");
  answer_once_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  err_empty_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  phase_clash_a: assert property (!(|(hs_on & ls_on)))
    else $error("both drivers of one phase on");
  chop_pair_a: assert property ($countones(hs_on) <= 2)
    else $error("three high sides on");
  adc_clock_a: assert property ($rose(supply_adc_clk) |-> adc_high_s ##[1:3] !supply_adc_clk)
    else $error("supply converter clock shape wrong");
  zc_mirror_a: assert property (zc_pin_out == $past(zero_crossing) || zc_pin_out == $past(ilim_trip))
    else $error("sense pin follows no comparator");
endmodule
`default_nettype wire

/* verif/sscs_motor_model.sv */
// Purpose: Motor, current comparator and supply reading around the sequencer.
// Assumes: Current builds while any high side conducts and decays when all are off.
// Notes:   The trip has hysteresis, so it outlives the drive cut as a real coil does.
`timescale 1ns/1ps
`default_nettype none
module sscs_motor_model #(
  parameter int ZC_PER = 1920
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       zc_run,
  input  wire logic [2:0] hs_on,
  output var  logic       zero_crossing,
  output var  logic       ilim_trip,
  output var  logic [5:0] supply_adc_data
);
  int zc_cnt_q;
  int amps_q;
  assign supply_adc_data = 6'h20;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zc_cnt_q <= 0;
      zero_crossing <= 1'b0;
    end else if (zc_run) begin
      zc_cnt_q <= (zc_cnt_q == ZC_PER - 1) ? 0 : zc_cnt_q + 1;
      zero_crossing <= zc_cnt_q >= ZC_PER / 2;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amps_q <= 0;
      ilim_trip <= 1'b0;
    end else begin
      if (|hs_on) amps_q <= (amps_q < 31) ? amps_q + 1 : 31;
      else if (amps_q > 0) amps_q <= amps_q - 1;
      if (amps_q >= 20) ilim_trip <= 1'b1;
      else if (amps_q == 0) ilim_trip <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/sscs_top_test.sv */
// Purpose: Self-checking bench for the spindle sequencer.
// Assumes: APB answers within a few cycles; motor period of 1920 clocks.
// Notes:   The bench plays the firmware side over APB.
`timescale 1ns/1ps
`default_nettype none
module sscs_top_test;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er, pv_u;
  logic        zero_crossing, ilim_trip, supply_adc_clk, zc_pin_out, sample_strobe, zc_run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  supply_adc_data;
  logic [2:0]  hs_on, ls_on;
  int          mismatches, n_compared, n_strobe;
  sscs_top u_sscs_top (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_crossing(zero_crossing),
    .ilim_trip(ilim_trip), .supply_adc_data(supply_adc_data),
    .supply_adc_clk(supply_adc_clk), .zc_pin_out(zc_pin_out),
    .sample_strobe(sample_strobe), .hs_on(hs_on), .ls_on(ls_on));
  sscs_motor_model u_sscs_motor_model (.clk(clk), .rst(rst), .zc_run(zc_run),
    .hs_on(hs_on), .zero_crossing(zero_crossing), .ilim_trip(ilim_trip),
    .supply_adc_data(supply_adc_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts strobes and flags any open window of phase U until the next zero crossing.
  task automatic zc_rise;
    int k;
    logic pv;
    k = 0;
    pv = 1'b1;
    while (!(zero_crossing === 1'b1 && pv === 1'b0) && k < 4000) begin
      pv = zero_crossing;
      @(posedge clk);
      k++;
      if (sample_strobe === 1'b1) n_strobe++;
      if (hs_on[0] === 1'b0 && ls_on[0] === 1'b0) pv_u = 1'b1;
    end
    if (k >= 4000) mismatches++;
  endtask
  task automatic t_regs;
    apb(1'b0, sscs_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, sscs_pkg::ADDR_AMP, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, sscs_pkg::ADDR_AMP, 32'h1a5);
    apb(1'b0, sscs_pkg::ADDR_AMP, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b1, 8'h18, 32'h1);
    chk(32'(er), 32'h1);
    apb(1'b1, sscs_pkg::ADDR_STAT, 32'hffffffff);
    apb(1'b0, sscs_pkg::ADDR_STAT, 32'h0);
    chk(rd & 32'h3f, 32'h0);
  endtask
  task automatic t_adc;
    int n, k;
    logic pv;
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, sscs_pkg::ADDR_CTRL, 32'(p) | 32'h2);
      apb(1'b0, sscs_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'(p) | 32'h2);
      n = -1;
      k = 0;
      pv = 1'b1;
      while (k < 40) begin
        @(posedge clk);
        k++;
        if (supply_adc_clk === 1'b1 && pv === 1'b0) begin
          if (n >= 0) break;
          n = 0;
        end
        if (n >= 0) n++;
        pv = supply_adc_clk;
      end
      chk(32'(n), (p == 0) ? 32'h8 : 32'h4);
    end
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
  endtask
  task automatic t_pos;
    apb(1'b1, sscs_pkg::ADDR_AMP, 32'hff);
    apb(1'b1, sscs_pkg::ADDR_OFFS, 32'h5);
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h8);
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, sscs_pkg::ADDR_STAT, 32'h0);
    chk(rd & 32'h3f, 32'h5);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h4);
      apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
    end
    apb(1'b0, sscs_pkg::ADDR_STAT, 32'h0);
    chk(rd & 32'h3f, 32'hd);
    chk(32'({hs_on, ls_on}), 32'h0);
  endtask
  task automatic t_sense;
    int k;
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h20);
    k = 0;
    while (ilim_trip !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    chk(32'(zc_pin_out), 32'h1);
    @(posedge clk);
    chk(32'(hs_on), 32'h0);
    apb(1'b0, sscs_pkg::ADDR_STAT, 32'h0);
    chk(32'(rd[16]), 32'h1);
    apb(1'b0, sscs_pkg::ADDR_RISE, 32'h0);
    chk(32'(rd != 32'h0), 32'h1);
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({hs_on, ls_on}), 32'h0);
  endtask
  task automatic t_six;
    logic gap, hi;
    gap = 1'b0;
    hi = 1'b0;
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h30);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 1100; k++) begin
      @(posedge clk);
      if ((|ls_on) !== 1'b1) gap = 1'b1;
      if ((|hs_on) === 1'b1) hi = 1'b1;
    end
    chk(32'(gap), 32'h0);
    chk(32'(hi), 32'h1);
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
  endtask
  task automatic t_closed;
    apb(1'b1, sscs_pkg::ADDR_OFFS, 32'h403);
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h60);
    zc_run <= 1'b1;
    repeat (3) zc_rise();
    apb(1'b0, sscs_pkg::ADDR_PER, 32'h0);
    chk(32'(rd >= 32'h13 && rd <= 32'h15), 32'h1);
    zc_rise();
    n_strobe = 0;
    pv_u = 1'b0;
    zc_rise();
    chk(32'(n_strobe >= 47 && n_strobe <= 49), 32'h1);
    chk(32'(pv_u), 32'h1);
    zc_run <= 1'b0;
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
  endtask
  // Second rise-to-rise span of high side W, after any period set before the write.
  task automatic t_pwm;
    int n;
    logic pv;
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h40 | 32'(2 * f));
      for (int r = 0; r < 3; r++) begin
        n = 0;
        pv = 1'b1;
        while (!(hs_on[2] === 1'b1 && pv === 1'b0) && n < 3000) begin
          pv = hs_on[2];
          @(posedge clk);
          n++;
        end
      end
      chk(32'(n), (f == 0) ? 32'h400 : 32'h402);
    end
    apb(1'b1, sscs_pkg::ADDR_CTRL, 32'h0);
  endtask
  task automatic summarize;
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    zc_run = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_adc();
    t_pos();
    t_sense();
    t_six();
    t_pwm();
    t_closed();
    summarize();
  end
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule
bind sscs_top sscs_checker #(.TC_W(TC_W), .RISE_W(RISE_W)) u_sscs_checker (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .zero_crossing(zero_crossing), .ilim_trip(ilim_trip),
  .supply_adc_data(supply_adc_data), .supply_adc_clk(supply_adc_clk),
  .zc_pin_out(zc_pin_out), .sample_strobe(sample_strobe), .hs_on(hs_on),
  .ls_on(ls_on));
`default_nettype wire
